//--- rtl/timer_a_pkg.sv
// Constants and types for the interval and time-base timer
//
// Summary of operation
// - Interval mode counts system prescaler taps /8192,/4096,/2048,/512,/256,/128,/32,/8.
// - Time-base mode gives overflow periods 1 s, 0.5 s, 0.25 s, 31.25 ms.
// - Every counter overflow sets the status flag; the interrupt line follows only when its mask bit is 1.
// - Clock output pin carries one of eight divided clocks or the undivided subclock.
// - Module standby stops the timer independently of the chip.
// - Reset loads the mode register with 10 hex.
// - Source bit 0: select 000-011 system /32../4, 100-111 subclock /32../4.
// - Source bit 1: output carries the undivided subclock.
// - Divided system clock outputs only in active and sleep modes.
// - Divided subclock outputs in active, sleep and subactive modes.
// - Mode register bit 4 reads as 1, writes ignored.
// - Time-base counter is clocked from the subclock prescaler /128, /64, /32 or /4 tap.
// - Counter is eight bits in both modes.
// - Counter increments per tick; FF wraps to 00 and sets overflow flag.
// - Clock select 0xxx system taps, 10xx periods, 11xx holds reset.
// - Time-base with clock select bit 2 set clears counter, and clears prescaler only outside standby.
// - Standby control bit 0 enters standby, 1 releases; reset value 1.
package timer_a_pkg;

  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_OUT_SEL    = 16'hff92;
  localparam logic [15:0] IDX_MODE       = 16'hffb0;
  localparam logic [15:0] IDX_COUNTER    = 16'hffb1;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hffc0;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'hffc1;
  localparam logic [15:0] IDX_CLK_STOP   = 16'hfffa;

  localparam logic [7:0] RST_MODE     = 8'h10;
  localparam logic [7:0] RST_COUNTER  = 8'h00;
  localparam logic [7:0] RST_CLK_STOP = 8'hff;
  localparam logic [7:0] RST_OUT_SEL  = 8'hfe;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] OUT_SEL_FIXED = 8'hfe;

  localparam int unsigned MODE_RSVD_BIT    = 4;
  localparam int unsigned STANDBY_BIT      = 0;
  localparam int unsigned OUT_SRC_BIT      = 0;
  localparam int unsigned OVF_STATUS_BIT   = 0;

  localparam int unsigned SYS_PRESC_W = 13;
  localparam int unsigned SUB_PRESC_W = 7;

  // Low bits that must be all ones for a tap tick (divide = 2**bits)
  localparam int unsigned SYS_TAP_BITS [8] = '{13, 12, 11, 9, 8, 7, 5, 3};
  // Time-base taps /128,/64,/32,/4 give 1 s,0.5 s,0.25 s,31.25 ms
  localparam int unsigned SUB_TAP_BITS [4] = '{7, 6, 5, 2};
  // Output divider bits for /32,/16,/8,/4
  localparam int unsigned OUT_DIV_BIT  [4] = '{4, 3, 2, 1};

  typedef struct packed {
    logic [2:0] out_sel;
    logic       reserved;
    logic       timebase;
    logic [2:0] clk_sel;
  } mode_reg_t;

  typedef enum logic [1:0] {
    PM_ACTIVE,
    PM_SLEEP,
    PM_SUBACTIVE,
    PM_WATCH
  } power_mode_t;

endpackage : timer_a_pkg

//--- rtl/interval_timebase_timer.sv
// Interval / time-base timer with clock output, APB register slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
module interval_timebase_timer
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [timer_a_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [timer_a_pkg::DATA_W-1:0]      pwdata,
  output logic      [timer_a_pkg::DATA_W-1:0]      prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                sub_clk,
  input  wire timer_a_pkg::power_mode_t            power_mode,
  output logic                                     clock_output_pin,
  output logic                                     irq
);

  // Register state
  timer_a_pkg::mode_reg_t                  mode_q,      mode_d;
  logic [7:0]                              counter_q,   counter_d;
  logic [7:0]                              clk_stop_q,  clk_stop_d;
  logic                                    out_src_q,   out_src_d;
  logic [7:0]                              status_q,    status_d;
  logic [7:0]                              mask_q,      mask_d;
  logic [timer_a_pkg::SYS_PRESC_W-1:0]     sys_presc_q, sys_presc_d;
  logic [timer_a_pkg::SUB_PRESC_W-1:0]     sub_presc_q, sub_presc_d;
  logic [timer_a_pkg::DATA_W-1:0]          prdata_q,    prdata_d;
  logic                                    pready_q,    pready_d;
  logic                                    pslverr_q,   pslverr_d;
  logic                                    clk_out_q,   clk_out_d;
  logic                                    irq_q,       irq_d;

  // Subclock synchroniser and edge history
  logic sub_meta_q;
  logic sub_sync_q;
  logic sub_prev_q;

  // Decode helpers
  logic                 setup;
  logic                 access;
  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_ok;
  logic [15:0]          idx;
  logic [7:0]           rd_val;
  logic                 sub_edge;
  logic                 standby;
  logic                 sys_run;
  logic                 sub_div_run;
  logic                 tb_hold;
  logic                 sys_tick;
  logic                 sub_tick;
  logic                 cnt_tick;
  logic                 overflow;

  function automatic logic tap_hit
  (
    input logic [timer_a_pkg::SYS_PRESC_W-1:0] cnt,
    input int unsigned                         bits
  );
    logic [timer_a_pkg::SYS_PRESC_W-1:0] m;
    m = '0;
    for (int i = 0; i < int'(timer_a_pkg::SYS_PRESC_W); i++)
    begin
      if (i < int'(bits))
      begin
        m[i] = 1'b1;
      end
    end
    tap_hit = ((cnt & m) == m);
  endfunction : tap_hit

  // Only the second and third stages are looked at by logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sub_meta_q <= 1'b0;
      sub_sync_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end
    else
    begin
      sub_meta_q <= sub_clk;
      sub_sync_q <= sub_meta_q;
      sub_prev_q <= sub_sync_q;
    end
  end

  // Bus decode; answer is prepared in the setup cycle
  always_comb
  begin
    setup   = psel && !penable;
    access  = psel && penable && pready_q;
    idx     = paddr[timer_a_pkg::ADDR_W-1:2];
    addr_ok = (paddr[1:0] == 2'h0) &&
              (idx == timer_a_pkg::IDX_OUT_SEL    ||
               idx == timer_a_pkg::IDX_MODE       ||
               idx == timer_a_pkg::IDX_COUNTER    ||
               idx == timer_a_pkg::IDX_IRQ_STATUS ||
               idx == timer_a_pkg::IDX_IRQ_MASK   ||
               idx == timer_a_pkg::IDX_CLK_STOP);
    wr_en   = access && pwrite && !pslverr_q;
    rd_en   = access && !pwrite && !pslverr_q;
  end

  // Read mux; unmapped indices read zero
  always_comb
  begin
    case (idx)
      timer_a_pkg::IDX_OUT_SEL:
        rd_val = timer_a_pkg::OUT_SEL_FIXED | {7'h00, out_src_q};
      timer_a_pkg::IDX_MODE:
        rd_val = {mode_q.out_sel, 1'b1, mode_q.timebase, mode_q.clk_sel};
      timer_a_pkg::IDX_COUNTER:
        rd_val = counter_q;
      timer_a_pkg::IDX_IRQ_STATUS:
        rd_val = status_q;
      timer_a_pkg::IDX_IRQ_MASK:
        rd_val = mask_q;
      timer_a_pkg::IDX_CLK_STOP:
        rd_val = clk_stop_q;
      default:
        rd_val = 8'h00;
    endcase
  end

  // Timing sources
  always_comb
  begin
    sub_edge    = sub_sync_q && !sub_prev_q;
    standby     = !clk_stop_q[timer_a_pkg::STANDBY_BIT];
    // System prescaler stands still when the system clock is stopped
    sys_run     = (power_mode == timer_a_pkg::PM_ACTIVE) ||
                  (power_mode == timer_a_pkg::PM_SLEEP);
    sub_div_run = sys_run ||
                  (power_mode == timer_a_pkg::PM_SUBACTIVE);
    tb_hold     = mode_q.timebase && mode_q.clk_sel[2];
  end

  // Tap ticks; a tick needs all low prescaler bits at one
  always_comb
  begin
    sys_tick    = sys_run &&
                  tap_hit(sys_presc_q,
                          timer_a_pkg::SYS_TAP_BITS[mode_q.clk_sel]);
    sub_tick    = sub_edge &&
                  tap_hit({{(timer_a_pkg::SYS_PRESC_W -
                             timer_a_pkg::SUB_PRESC_W){1'b0}},
                           sub_presc_q},
                          timer_a_pkg::SUB_TAP_BITS[mode_q.clk_sel[1:0]]);
    cnt_tick    = !standby && !tb_hold &&
                  (mode_q.timebase ? sub_tick : sys_tick);
    overflow    = cnt_tick && (counter_q == 8'hff);
  end

  // Bus answer, prepared in the setup cycle so pready never waits
  always_comb
  begin
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (setup)
    begin
      pready_d  = 1'b1;
      pslverr_d = !addr_ok;
      prdata_d  = addr_ok ? {24'h000000, rd_val} : 32'h00000000;
    end
    else if (psel && penable && !pready_q)
    begin
      pready_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Software settings; writes land at the access edge only
  always_comb
  begin
    mode_d     = mode_q;
    clk_stop_d = clk_stop_q;
    out_src_d  = out_src_q;
    mask_d     = mask_q;
    if (wr_en)
    begin
      case (idx)
        timer_a_pkg::IDX_MODE:
        begin
          mode_d          = timer_a_pkg::mode_reg_t'(pwdata[7:0]);
          mode_d.reserved = 1'b1;
        end
        timer_a_pkg::IDX_OUT_SEL:
          out_src_d = pwdata[timer_a_pkg::OUT_SRC_BIT];
        timer_a_pkg::IDX_IRQ_MASK:
          mask_d = pwdata[7:0];
        timer_a_pkg::IDX_CLK_STOP:
          clk_stop_d = pwdata[7:0];
        // Counter and status ignore writes without an error
        default:
          mask_d = mask_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q     <= timer_a_pkg::mode_reg_t'(timer_a_pkg::RST_MODE);
      clk_stop_q <= timer_a_pkg::RST_CLK_STOP;
      out_src_q  <= timer_a_pkg::RST_OUT_SEL[timer_a_pkg::OUT_SRC_BIT];
      mask_q     <= timer_a_pkg::RST_IRQ_MASK;
    end
    else
    begin
      mode_q     <= mode_d;
      clk_stop_q <= clk_stop_d;
      out_src_q  <= out_src_d;
      mask_q     <= mask_d;
    end
  end

  // Prescalers; standby freezes them instead of clearing
  always_comb
  begin
    sys_presc_d = sys_presc_q;
    sub_presc_d = sub_presc_q;
    if (!standby)
    begin
      if (sys_run)
      begin
        sys_presc_d = sys_presc_q +
                      {{(timer_a_pkg::SYS_PRESC_W-1){1'b0}}, 1'b1};
      end
      // The time-base hold clears this prescaler only while the module runs
      if (tb_hold)
      begin
        sub_presc_d = '0;
      end
      else if (sub_edge)
      begin
        sub_presc_d = sub_presc_q +
                      {{(timer_a_pkg::SUB_PRESC_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_presc_q <= '0;
      sub_presc_q <= '0;
    end
    else
    begin
      sys_presc_q <= sys_presc_d;
      sub_presc_q <= sub_presc_d;
    end
  end

  // Eight-bit up counter
  always_comb
  begin
    counter_d = counter_q;
    if (tb_hold)
    begin
      counter_d = 8'h00;
    end
    else if (cnt_tick)
    begin
      counter_d = counter_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_q <= timer_a_pkg::RST_COUNTER;
    end
    else
    begin
      counter_q <= counter_d;
    end
  end

  // Sticky status and the interrupt level
  always_comb
  begin
    status_d = status_q;
    // Read clears status; an overflow in the same cycle still lands
    if (rd_en && idx == timer_a_pkg::IDX_IRQ_STATUS)
    begin
      status_d = 8'h00;
    end
    if (overflow)
    begin
      status_d[timer_a_pkg::OVF_STATUS_BIT] = 1'b1;
    end
    // Mask taken as registered, so a mask write acts a cycle later
    irq_d = |(status_d & mask_q);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= 8'h00;
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_q    <= irq_d;
    end
  end

  // Output mux; standby parks the divided choices low
  always_comb
  begin
    clk_out_d = 1'b0;
    if (out_src_q)
    begin
      clk_out_d = sub_sync_q;
    end
    else if (!standby)
    begin
      if (!mode_q.out_sel[2])
      begin
        clk_out_d = sys_run &&
          sys_presc_q[timer_a_pkg::OUT_DIV_BIT[mode_q.out_sel[1:0]]];
      end
      else
      begin
        clk_out_d = sub_div_run &&
          sub_presc_q[timer_a_pkg::OUT_DIV_BIT[mode_q.out_sel[1:0]]];
      end
    end
  end

  // Registered so the pin never glitches on a select change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_out_q <= 1'b0;
    end
    else
    begin
      clk_out_q <= clk_out_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign clock_output_pin = clk_out_q;
  assign irq              = irq_q;

endmodule : interval_timebase_timer

//--- sim/timer_monitor.sv
// Bus and interrupt checks for the interval and time-base timer
`timescale 1ns/100ps
module timer_monitor
(
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [timer_a_pkg::ADDR_W-1:0] paddr,
  input wire logic [timer_a_pkg::DATA_W-1:0] prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  input wire logic                           irq
);
  logic done;
  logic touch;
  assign done  = psel && penable && pready;
  // Status read drops the interrupt a cycle later, mask write two cycles later
  assign touch = done && ((paddr[17:2] == timer_a_pkg::IDX_IRQ_STATUS &&
                 !pwrite) || (paddr[17:2] == timer_a_pkg::IDX_IRQ_MASK &&
                 pwrite));
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_zero_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_misalign_err: assert property (pready && paddr[1:0] != 2'b00
    |-> pslverr) else $error("misaligned access accepted");
  chk_mode_bit_four: assert property (done && !pwrite && !pslverr &&
    paddr[17:2] == timer_a_pkg::IDX_MODE |-> prdata[4])
    else $error("mode bit 4 read as 0");
  chk_outsel_fixed: assert property (done && !pwrite && !pslverr &&
    paddr[17:2] == timer_a_pkg::IDX_OUT_SEL |-> prdata[7:1] == 7'h7f)
    else $error("output select fixed bits wrong");
  chk_irq_held: assert property (irq && !touch && !$past(touch)
    |=> irq) else $error("interrupt dropped without clear");
endmodule : timer_monitor

bind interval_timebase_timer timer_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq));

//--- sim/tb_top.sv
// Self-checking bench for the interval and time-base timer
`timescale 1ns/100ps
module tb_top;
  localparam logic [17:0] A_OUT  = {timer_a_pkg::IDX_OUT_SEL, 2'b00};
  localparam logic [17:0] A_MODE = {timer_a_pkg::IDX_MODE, 2'b00};
  localparam logic [17:0] A_CNT  = {timer_a_pkg::IDX_COUNTER, 2'b00};
  localparam logic [17:0] A_STAT = {timer_a_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] A_MASK = {timer_a_pkg::IDX_IRQ_MASK, 2'b00};
  localparam logic [17:0] A_STOP = {timer_a_pkg::IDX_CLK_STOP, 2'b00};
  logic                      pclk = 1'b0;
  logic                      presetn = 1'b0;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [17:0]               paddr = 18'h0;
  logic [31:0]               pwdata = 32'h0;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      sub_clk = 1'b0;
  logic [2:0]                sub_div = 3'h0;
  timer_a_pkg::power_mode_t  power_mode = timer_a_pkg::PM_ACTIVE;
  logic                      clock_output_pin;
  logic                      irq;
  logic [31:0]               rdat;
  logic                      rerr;
  int                        n_mismatch = 0;
  int                        checks_done = 0;

  interval_timebase_timer uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sub_clk(sub_clk), .power_mode(power_mode),
    .clock_output_pin(clock_output_pin), .irq(irq));

  always #25 pclk = ~pclk;
  // Subclock far faster than a real crystal to keep the run short
  always @(posedge pclk)
  begin
    sub_div <= sub_div + 3'h1;
    if (sub_div == 3'h7)
      sub_clk <= ~sub_clk;
  end

  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    @(posedge pclk);
    for (n = 1; n < 8 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      print_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [17:0] a, input logic [31:0] e,
                      input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask : rchk

  // Rising edges of the clock output over a whole number of periods
  task automatic rises(input int cyc, input int e, input string nm);
    int   r;
    logic p;
    r = 0;
    repeat (8) @(negedge pclk);
    p = clock_output_pin;
    repeat (cyc)
    begin
      @(negedge pclk);
      if (clock_output_pin === 1'b1 && p === 1'b0)
        r++;
      p = clock_output_pin;
    end
    chk(nm, 32'(e), 32'(r));
  endtask : rises

  task automatic t_reset;
    rchk(A_MODE, 32'h10, "mode reset");
    rchk(A_CNT, 32'h0, "counter reset");
    rchk(A_STOP, 32'hff, "clock stop reset");
    rchk(A_OUT, 32'hfe, "output select reset");
    rchk(A_MASK, 32'h0, "mask reset");
  endtask : t_reset

  task automatic t_access;
    wr(A_MODE, 32'h00);
    rchk(A_MODE, 32'h10, "mode bit 4 set");
    wr(A_MODE, 32'hef);
    rchk(A_MODE, 32'hff, "mode all ones");
    apb(1'b1, A_MODE + 18'h1, 32'h00);
    chk("misaligned error", 32'h1, {31'h0, rerr});
    rchk(A_MODE, 32'hff, "mode kept");
    apb(1'b0, 18'h00004, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
  endtask : t_access

  task automatic t_clk_out;
    wr(A_MODE, 32'h60);
    rises(32, 8, "system div 4");
    wr(A_MODE, 32'h00);
    rises(64, 2, "system div 32");
    power_mode <= timer_a_pkg::PM_SUBACTIVE;
    wr(A_MODE, 32'he0);
    rises(128, 2, "sub div 4");
    wr(A_MODE, 32'h60);
    rises(32, 0, "system div off");
    power_mode <= timer_a_pkg::PM_ACTIVE;
    wr(A_OUT, 32'h01);
    rises(64, 4, "sub undivided");
    wr(A_OUT, 32'h00);
  endtask : t_clk_out

  task automatic t_overflow;
    int   n;
    logic seen;
    wr(A_MODE, 32'h0c);
    rchk(A_CNT, 32'h0, "time base clear");
    wr(A_MASK, 32'h1);
    wr(A_MODE, 32'h07);
    for (n = 0; n < 2100 && irq !== 1'b1; n++)
      @(negedge pclk);
    chk("overflow time", 32'h1, 32'(n > 2030 && n < 2060));
    if (n == 2100)
      print_verdict();
    rchk(A_STAT, 32'h1, "status set");
    rchk(A_STAT, 32'h0, "status cleared");
    @(negedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(A_MASK, 32'h0);
    seen = 1'b0;
    repeat (2100)
    begin
      @(negedge pclk);
      seen = seen | irq;
    end
    chk("irq masked", 32'h0, {31'h0, seen});
    rchk(A_STAT, 32'h1, "masked status");
  endtask : t_overflow

  task automatic t_standby;
    logic [31:0] c;
    wr(A_STOP, 32'hfe);
    apb(1'b0, A_CNT, 32'h0);
    c = rdat;
    repeat (100) @(posedge pclk);
    rchk(A_CNT, c, "counter frozen");
    wr(A_STOP, 32'hff);
    rchk(A_STOP, 32'hff, "standby released");
    repeat (100) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    chk("counter runs", 32'h1, 32'(rdat != c));
  endtask : t_standby

  // Counter advance over a fixed wait from a cleared counter
  task automatic rate_chk(input logic [31:0] m, input int lo,
                          input int hi, input string nm);
    wr(A_MODE, 32'h0c);
    wr(A_MODE, m);
    repeat (1280) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    chk(nm, 32'h1, 32'(int'(rdat) >= lo && int'(rdat) <= hi));
  endtask : rate_chk

  task automatic t_rates;
    rate_chk(32'h05, 10, 11, "interval div 128");
    rate_chk(32'h0b, 19, 21, "time base div 4");
    rate_chk(32'h0a, 2, 2, "time base div 32");
  endtask : t_rates

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_access();
    t_clk_out();
    t_overflow();
    t_standby();
    t_rates();
    print_verdict();
  end
endmodule : tb_top
